/* File: include/pac_pkg.sv */
// Package for the pulse accumulator counter block: register map, field
// positions, reset values, timing counts and the structs carried on ports.
// Assumes a single 250 MHz clock domain and an 8-bit register port.
package pac_pkg;

   // Register port geometry.
   localparam int          PAC_ADDR_W = 8;
   localparam int          PAC_DATA_W = 8;

   // Register offsets on the plain register port.
   localparam logic [7:0]  PAC_OFF_CONTROL = 8'h00; // accum_control_reg
   localparam logic [7:0]  PAC_OFF_COUNT   = 8'h01; // accum_count_reg
   localparam logic [7:0]  PAC_OFF_MASK2   = 8'h02; // timer_mask_reg_two
   localparam logic [7:0]  PAC_OFF_FLAG2   = 8'h03; // timer_flag_reg_two

   // Control register field positions.
   localparam int          PAC_CTL_ENABLE_BIT = 6;
   localparam int          PAC_CTL_MODE_BIT   = 5;
   localparam int          PAC_CTL_EDGE_BIT   = 4;
   localparam int          PAC_CTL_CCSEL_BIT  = 2;
   localparam int          PAC_CTL_RATE_LSB   = 0;

   // Mask and flag register field positions (same layout in both).
   localparam int          PAC_IRQ_PERIODIC_BIT = 6;
   localparam int          PAC_IRQ_OVF_BIT      = 5;
   localparam int          PAC_IRQ_EDGE_BIT     = 4;

   // Timing: gated time base divider and periodic divider.
   localparam int          PAC_GATE_DIV      = 64;
   localparam int          PAC_GATE_DIV_W    = 6;
   localparam logic [5:0]  PAC_GATE_DIV_LAST = 6'(PAC_GATE_DIV - 1);
   localparam int          PAC_PERIODIC_LOG2 = 13;
   localparam int          PAC_PERIODIC_W    = 16;

   // Counter wrap point.
   localparam logic [7:0]  PAC_COUNT_MAX = 8'hFF;

   // Control register fields.
   typedef struct packed {
      logic       enable;   // accum_enable
      logic       mode;     // accum_mode_sel: 0 event, 1 gated
      logic       edgeSel;  // accum_edge_sel
      logic       ccSel;    // capture_compare_sel
      logic [1:0] rate;     // periodic_rate_sel
   } pac_ctrl_t;

   // One bit for each event source; used for flags, enables and requests.
   typedef struct packed {
      logic periodic;
      logic ovf;
      logic edgeEv;
   } pac_irq_t;

   // Register port request from software.
   typedef struct packed {
      logic                  wr;
      logic                  rd;
      logic [PAC_ADDR_W-1:0] addr;
      logic [PAC_DATA_W-1:0] wdata;
   } pac_bus_req_t;

   // Reset values.
   localparam pac_ctrl_t   PAC_CTRL_RST = '{default: 1'b0};
   localparam pac_irq_t    PAC_IRQ_RST  = '{default: 1'b0};

endpackage

/* File: verilog/pac_accumulator.sv */
// Pulse accumulator counter: 8-bit event counter or gated time
// accumulator, with overflow, input-edge and periodic flags.
// Assumes accumInputPin and the register port are synchronous to ref_clk.
//
// Local design decisions: the address-and-strobe port and the placing of the registers.

// Contract
// RULE1 - 8-bit counter works as event counter or gated time accumulator.
// RULE2 - Outside source toggles the input no faster than half the clock.
// RULE3 - Gated mode counts a free divide-by-64 tick while input active.
// RULE4 - Enable bit 0 stops the whole accumulator, 1 runs it; the periodic timer and flag run on with enable 0.
// RULE5 - Mode bit 0 selects event counting, 1 gated accumulation.
// RULE6 - Event mode: edge bit 0 counts falling edges, 1 rising edges.
// RULE7 - Gated mode: edge bit 0 stops on low input, 1 on high.
// RULE8 - Select bit 0 enables fifth compare, 1 enables fourth capture.
// RULE9 - Periodic logic runs from a 2^13 tick plus a rate divider.
// RULE10 - Count survives reset and is readable and writable anytime.
// RULE11 - Count reads return the accumulated value with gate inactive.
// RULE12 - Increments and software reads never collide.
// RULE13 - Overflow flag sets when the count wraps from FF to 00.
// RULE14 - Writing one to flag bit 5 clears the overflow flag.
// RULE15 - Overflow enable gates the request only, never the flag.
// RULE16 - Edge flag sets on each selected input edge.
// RULE17 - Writing one to flag bit 4 clears the edge flag.
// RULE18 - Edge enable gates the request only, never the flag.
// RULE19 - Service software clears the flag before returning.
// RULE20 - Rate values 0 to 3 give periods of 2^13 to 2^16 clocks.
// RULE21 - Each period runs from the previous timeout, not the clear.
// RULE22 - A count write replaces the count; counting continues from it.
// RULE23 - Flag bits written as zero leave their flags unchanged.
module pac_accumulator #(
   parameter int PERIODIC_LOG2 = pac_pkg::PAC_PERIODIC_LOG2
) (
   input  wire logic                 ref_clk,          // 250 MHz clock.
   input  wire logic                 srst,             // Sync reset, high.
   input  wire pac_pkg::pac_bus_req_t busReq,          // Register request.
   output      logic [7:0]           busRdata,         // Read data, +1 cycle.
   input  wire logic                 accumInputPin,    // Event or gate pin.
   output      pac_pkg::pac_irq_t    irqReq,           // Request per source.
   output      logic                 fifthOcEnable,    // Compare 5 on.
   output      logic                 fourthIcEnable    // Capture 4 on.
);
   import pac_pkg::*;

   // The rate field adds up to three more divide-by-two stages.
   if (PERIODIC_LOG2 < 1 || PERIODIC_LOG2 + 3 > PAC_PERIODIC_W) begin : g_chk
      $error("PERIODIC_LOG2 out of range for the periodic counter");
   end

   // Whole state of the block in one record.
   typedef struct packed {
      pac_ctrl_t                 ctrl;
      pac_irq_t                  mask;
      pac_irq_t                  flags;
      logic [7:0]                count;
      logic                      pinPrev;
      logic [PAC_GATE_DIV_W-1:0] gateDiv;
      logic [PAC_PERIODIC_W-1:0] perCnt;
      logic [7:0]                rdata;
      pac_irq_t                  irq;
      logic                      ocEn;
      logic                      icEn;
   } pac_state_t;

   pac_state_t state_reg;
   pac_state_t state_next;

   // Address match, used for every register decode.
   function automatic logic addrHit(input logic [7:0] a,
                                    input logic [7:0] off);
      return a == off;
   endfunction

   logic                      wrCtrl;
   logic                      wrCount;
   logic                      wrMask;
   logic                      wrFlag;
   logic                      pinRise;
   logic                      pinFall;
   logic                      selEdge;
   logic                      gateActive;
   logic                      gateTick;
   logic                      countInc;
   logic                      countWrap;
   logic                      perTimeout;
   logic [PAC_PERIODIC_W-1:0] perLast;
   logic [7:0]                readMux;

   // Decodes of software writes.
   assign wrCtrl  = busReq.wr && addrHit(busReq.addr, PAC_OFF_CONTROL);
   assign wrCount = busReq.wr && addrHit(busReq.addr, PAC_OFF_COUNT);
   assign wrMask  = busReq.wr && addrHit(busReq.addr, PAC_OFF_MASK2);
   assign wrFlag  = busReq.wr && addrHit(busReq.addr, PAC_OFF_FLAG2);

   // Input edges; the source keeps each level at least one clock.
   assign pinRise = accumInputPin && !state_reg.pinPrev; // see RULE2
   assign pinFall = !accumInputPin && state_reg.pinPrev;
   // The counted edge in event mode is also the gate's trailing edge.
   assign selEdge = state_reg.ctrl.edgeSel ? pinRise : pinFall; // see RULE6
   assign gateActive = state_reg.ctrl.edgeSel ? !accumInputPin
                                              : accumInputPin; // see RULE7
   assign gateTick = state_reg.gateDiv == PAC_GATE_DIV_LAST; // see RULE3

   // Count step: gated tick or selected edge, only while enabled.
   always_comb begin
      countInc = 1'b0;
      if (state_reg.ctrl.enable) begin // see RULE4
         if (state_reg.ctrl.mode) begin // see RULE5
            countInc = gateTick && gateActive; // see RULE3
         end else begin
            countInc = selEdge; // see RULE1
         end
      end
   end
   assign countWrap = countInc && (state_reg.count == PAC_COUNT_MAX);

   // Periodic interval: 2^(base+rate) clocks from the last timeout.
   // A greater-or-equal compare keeps a lowered rate from a long wrap.
   assign perLast = PAC_PERIODIC_W'((17'h1 << (PERIODIC_LOG2
                    + int'(state_reg.ctrl.rate))) - 17'h1); // see RULE20
   assign perTimeout = state_reg.perCnt >= perLast; // see RULE9

   // Read data; reserved bits read as zero, unmapped offsets read zero.
   always_comb begin
      readMux = 8'h00;
      if (addrHit(busReq.addr, PAC_OFF_CONTROL)) begin
         readMux[PAC_CTL_ENABLE_BIT] = state_reg.ctrl.enable;
         readMux[PAC_CTL_MODE_BIT]   = state_reg.ctrl.mode;
         readMux[PAC_CTL_EDGE_BIT]   = state_reg.ctrl.edgeSel;
         readMux[PAC_CTL_CCSEL_BIT]  = state_reg.ctrl.ccSel;
         readMux[PAC_CTL_RATE_LSB +: 2] = state_reg.ctrl.rate;
      end else if (addrHit(busReq.addr, PAC_OFF_COUNT)) begin
         readMux = state_reg.count; // see RULE11
      end else if (addrHit(busReq.addr, PAC_OFF_MASK2)) begin
         readMux[PAC_IRQ_PERIODIC_BIT] = state_reg.mask.periodic;
         readMux[PAC_IRQ_OVF_BIT]      = state_reg.mask.ovf;
         readMux[PAC_IRQ_EDGE_BIT]     = state_reg.mask.edgeEv;
      end else if (addrHit(busReq.addr, PAC_OFF_FLAG2)) begin
         readMux[PAC_IRQ_PERIODIC_BIT] = state_reg.flags.periodic;
         readMux[PAC_IRQ_OVF_BIT]      = state_reg.flags.ovf;
         readMux[PAC_IRQ_EDGE_BIT]     = state_reg.flags.edgeEv;
      end
   end

   // Next state. Reset restores everything except the count.
   always_comb begin
      state_next = state_reg;
      state_next.pinPrev = accumInputPin;
      // The divide-by-64 base runs free so the gate sees a steady tick.
      state_next.gateDiv = state_reg.gateDiv + 1'b1; // see RULE3
      state_next.perCnt  = perTimeout ? '0
                                      : state_reg.perCnt + 1'b1; // see RULE21
      if (wrCtrl) begin
         state_next.ctrl.enable  = busReq.wdata[PAC_CTL_ENABLE_BIT];
         state_next.ctrl.mode    = busReq.wdata[PAC_CTL_MODE_BIT];
         state_next.ctrl.edgeSel = busReq.wdata[PAC_CTL_EDGE_BIT];
         state_next.ctrl.ccSel   = busReq.wdata[PAC_CTL_CCSEL_BIT];
         state_next.ctrl.rate    = busReq.wdata[PAC_CTL_RATE_LSB +: 2];
      end
      if (wrMask) begin
         state_next.mask.periodic = busReq.wdata[PAC_IRQ_PERIODIC_BIT];
         state_next.mask.ovf      = busReq.wdata[PAC_IRQ_OVF_BIT];
         state_next.mask.edgeEv   = busReq.wdata[PAC_IRQ_EDGE_BIT];
      end
      // A count write wins over a step that lands in the same cycle;
      // reads use the registered count, so they never see a half step.
      if (wrCount) begin
         state_next.count = busReq.wdata; // see RULE22
      end else if (countInc) begin
         state_next.count = state_reg.count + 1'b1; // see RULE12
      end
      // Clears by writing ones; a new event in the same cycle wins.
      if (wrFlag) begin
         if (busReq.wdata[PAC_IRQ_PERIODIC_BIT]) begin
            state_next.flags.periodic = 1'b0;
         end
         if (busReq.wdata[PAC_IRQ_OVF_BIT]) begin
            state_next.flags.ovf = 1'b0; // see RULE14 and RULE23
         end
         if (busReq.wdata[PAC_IRQ_EDGE_BIT]) begin
            state_next.flags.edgeEv = 1'b0; // see RULE17
         end
      end
      if (perTimeout) begin
         state_next.flags.periodic = 1'b1;
      end
      if (countWrap) begin
         state_next.flags.ovf = 1'b1; // see RULE13
      end
      if (state_reg.ctrl.enable && selEdge) begin
         state_next.flags.edgeEv = 1'b1; // see RULE16
      end
      // Requests follow flag and enable; enables never touch flags.
      state_next.irq = state_next.flags & state_next.mask; // see RULE15
      state_next.ocEn = !state_next.ctrl.ccSel; // see RULE8
      state_next.icEn = state_next.ctrl.ccSel;
      state_next.rdata = busReq.rd ? readMux : 8'h00;
      if (srst) begin
         state_next.ctrl    = PAC_CTRL_RST;
         state_next.mask    = PAC_IRQ_RST;
         state_next.flags   = PAC_IRQ_RST;
         state_next.irq     = PAC_IRQ_RST;
         state_next.pinPrev = 1'b0;
         state_next.gateDiv = '0;
         state_next.perCnt  = '0;
         state_next.rdata   = 8'h00;
         state_next.ocEn    = 1'b1;
         state_next.icEn    = 1'b0;
         state_next.count   = state_reg.count; // see RULE10
      end
   end

   // Single state register; reset is handled in the next-state logic.
   always_ff @(posedge ref_clk) begin
      state_reg <= state_next;
   end

   // Outputs straight from the state register.
   assign busRdata       = state_reg.rdata;
   assign irqReq         = state_reg.irq; // see RULE18
   assign fifthOcEnable  = state_reg.ocEn;
   assign fourthIcEnable = state_reg.icEn;

   // Checks on the block's own behaviour.
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   sequence s_wrap;
      countWrap && !wrCount;
   endsequence

   sequence s_gated_step;
      state_reg.ctrl.enable && state_reg.ctrl.mode && gateTick
         && gateActive && !wrCount;
   endsequence

   sequence s_event_step;
      state_reg.ctrl.enable && !state_reg.ctrl.mode && selEdge && !wrCount;
   endsequence

   a_wrap_sets_ovf: assert property ( // see RULE13
      s_wrap |=> state_reg.flags.ovf && state_reg.count == 8'h00)
      else $error("overflow flag or zero count missing after wrap");

   a_gated_step: assert property ( // see RULE3
      s_gated_step |=> state_reg.count == 8'($past(state_reg.count) + 1))
      else $error("gated tick did not advance the count");

   a_event_step: assert property ( // see RULE6
      s_event_step |=> state_reg.count == 8'($past(state_reg.count) + 1))
      else $error("selected edge did not advance the count");

   a_gate_inhibit: assert property ( // see RULE7
      state_reg.ctrl.mode && !gateActive && !wrCount
      |=> state_reg.count == $past(state_reg.count))
      else $error("count moved while the gate was inactive");

   a_disabled_hold: assert property ( // see RULE4
      !state_reg.ctrl.enable && !wrCount
      |=> $stable(state_reg.count) && !state_reg.flags.edgeEv
          || $past(state_reg.flags.edgeEv))
      else $error("disabled accumulator changed count or edge flag");

   a_count_write: assert property ( // see RULE22
      wrCount |=> state_reg.count == $past(busReq.wdata))
      else $error("count write not taken");

   a_count_read: assert property ( // see RULE11
      busReq.rd && addrHit(busReq.addr, PAC_OFF_COUNT)
      |=> busRdata == $past(state_reg.count))
      else $error("count read returned a wrong value");

   a_ovf_clear: assert property ( // see RULE14
      wrFlag && busReq.wdata[PAC_IRQ_OVF_BIT] && !countWrap
      |=> !state_reg.flags.ovf)
      else $error("overflow flag not cleared by a one");

   a_flag_keep: assert property ( // see RULE23
      wrFlag && !busReq.wdata[PAC_IRQ_EDGE_BIT] && state_reg.flags.edgeEv
      |=> state_reg.flags.edgeEv)
      else $error("edge flag cleared by a zero");

   // The flag may only drop again through a clear written one cycle on.
   a_edge_flag: assert property ( // see RULE16
      state_reg.ctrl.enable && selEdge |=> state_reg.flags.edgeEv
      ##1 (state_reg.flags.edgeEv
           || $past(wrFlag && busReq.wdata[PAC_IRQ_EDGE_BIT])))
      else $error("edge flag not set on selected edge");

   // A set flag with its enable on must show as a request.
   a_edge_request: assert property ( // see RULE18
      state_reg.flags.edgeEv && state_reg.mask.edgeEv |-> irqReq.edgeEv)
      else $error("edge request missing while flag and enable set");

   // The two timer functions are never enabled together.
   a_select_outputs: assert property ( // see RULE8
      fifthOcEnable == !state_reg.ctrl.ccSel
      && fourthIcEnable == state_reg.ctrl.ccSel)
      else $error("capture and compare enables disagree with select");

   // Read data stand only in the cycle after a read strobe.
   a_rdata_idle: assert property ( // see RULE11
      !busReq.rd |=> busRdata == 8'h00)
      else $error("read data not zero outside a read answer");

   a_ovf_request: assert property ( // see RULE15
      s_wrap ##1 state_reg.mask.ovf |-> irqReq.ovf)
      else $error("overflow request missing while enabled");

   a_periodic_flag: assert property ( // see RULE21
      perTimeout |=> state_reg.flags.periodic && state_reg.perCnt == '0)
      else $error("periodic timeout did not set flag and restart");

endmodule // pac_accumulator

/* File: verif/pac_pin_model.sv */
// Model of the outside source that drives the accumulator input pin.
// Assumes the bench calls its tasks from a process clocked by ref_clk.
module pac_pin_model (
   input  wire logic ref_clk,       // Block clock.
   output      logic accumInputPin  // Event or gate level.
);
   timeunit 1ns;
   timeprecision 100ps;

   // The pin starts low so the first rising edge is a real event.
   initial accumInputPin = 1'b0;

   // Hold a level for some cycles; two at least, so the source stays
   // below half the clock rate and the block never misses an edge.
   task automatic hold(input logic lvl, input int cycles);
      int n;
      n = (cycles < 2) ? 2 : cycles;
      @(posedge ref_clk);
      accumInputPin <= lvl;
      repeat (n - 1) @(posedge ref_clk);
   endtask

   // Whole high-then-low pulses, each level held for width cycles.
   task automatic pulses(input int count, input int width);
      for (int i = 0; i < count; i++) begin
         hold(1'b1, width);
         hold(1'b0, width);
      end
   endtask
endmodule // pac_pin_model

/* File: verif/pulse_accumulator_counter_bench.sv */
// Self-checking bench for the pulse accumulator counter block.
// Assumes the package pac_pkg and the pin model are compiled first.
module pulse_accumulator_counter_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import pac_pkg::*;

   localparam int PLOG2 = 3;  // Short periodic base keeps the run brief.

   logic         ref_clk;
   logic         srst;
   pac_bus_req_t busReq;
   logic [7:0]   busRdata;
   logic         accumInputPin;
   pac_irq_t     irqReq;
   logic         fifthOcEnable;
   logic         fourthIcEnable;
   logic [7:0]   rdVal;
   int           nErrors;
   int           nCompared;
   int           cyc;

   pac_accumulator #(.PERIODIC_LOG2(PLOG2)) pac_accumulator_inst (
      .ref_clk(ref_clk), .srst(srst), .busReq(busReq), .busRdata(busRdata),
      .accumInputPin(accumInputPin), .irqReq(irqReq),
      .fifthOcEnable(fifthOcEnable), .fourthIcEnable(fourthIcEnable));
   pac_pin_model pac_pin_model_inst (
      .ref_clk(ref_clk), .accumInputPin(accumInputPin));

   // Free clock at 250 MHz and a cycle count for period measurements.
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   initial cyc = 0;
   always @(posedge ref_clk) cyc <= cyc + 1;

   // Compare one byte and count it; a difference is reported at once.
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      nCompared++;
      if (seen !== exp) begin
         $display("mismatch at %0t: got %h want %h", $time, seen, exp);
         nErrors++;
      end
   endtask

   // Single place where the run ends.
   task automatic test_done();
      if (nErrors == 0 && nCompared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // One-cycle write strobe; the write lands on the edge that drops it.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge ref_clk);
      busReq.wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so sample there.
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] m,
                         input logic [7:0] exp);
      @(posedge ref_clk);
      busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge ref_clk);
      busReq.rd <= 1'b0;
      #1;
      rdVal = busRdata;
      check(rdVal & m, exp);
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   task automatic do_reset();
      @(posedge ref_clk);
      srst <= 1'b1;
      busReq <= '0;
      repeat (10) @(posedge ref_clk);
      srst <= 1'b0;
   endtask

   // Reset values, reserved bits, unmapped place and the select outputs.
   task automatic t_regs();
      settle(1);
      check({7'h00, fifthOcEnable}, 8'h01);
      check({5'h00, irqReq}, 8'h00);
      rd_chk(PAC_OFF_CONTROL, 8'hFF, 8'h00);
      wr(PAC_OFF_CONTROL, 8'hFF);
      rd_chk(PAC_OFF_CONTROL, 8'hFF, 8'h77);
      check({6'h00, fourthIcEnable, fifthOcEnable}, 8'h02);
      settle(1);
      check(busRdata, 8'h00);
      wr(PAC_OFF_CONTROL, 8'h00);
      settle(1);
      check({6'h00, fourthIcEnable, fifthOcEnable}, 8'h01);
      wr(PAC_OFF_MASK2, 8'hFF);
      rd_chk(PAC_OFF_MASK2, 8'hFF, 8'h70);
      wr(PAC_OFF_MASK2, 8'h00);
      wr(8'h10, 8'hFF);
      rd_chk(8'h10, 8'hFF, 8'h00);
   endtask

   // A written count is kept through a reset.
   task automatic t_count();
      wr(PAC_OFF_COUNT, 8'h5A);
      rd_chk(PAC_OFF_COUNT, 8'hFF, 8'h5A);
      do_reset();
      rd_chk(PAC_OFF_COUNT, 8'hFF, 8'h5A);
   endtask

   // Event counting on both edges, wrap, flags and their requests.
   task automatic t_event();
      wr(PAC_OFF_FLAG2, 8'h70);
      wr(PAC_OFF_CONTROL, 8'h50);
      wr(PAC_OFF_COUNT, 8'hFD);
      pac_pin_model_inst.pulses(2, 2);
      rd_chk(PAC_OFF_COUNT, 8'hFF, 8'hFF);
      rd_chk(PAC_OFF_FLAG2, 8'h30, 8'h10);
      check({7'h00, irqReq.edgeEv}, 8'h00);
      pac_pin_model_inst.pulses(1, 2);
      rd_chk(PAC_OFF_COUNT, 8'hFF, 8'h00);
      rd_chk(PAC_OFF_FLAG2, 8'h30, 8'h30);
      check({7'h00, irqReq.ovf}, 8'h00);
      wr(PAC_OFF_MASK2, 8'h30);
      settle(2);
      check({6'h00, irqReq.ovf, irqReq.edgeEv}, 8'h03);
      // Service clears one flag at a time, as an interrupt handler would.
      wr(PAC_OFF_FLAG2, 8'h20);
      rd_chk(PAC_OFF_FLAG2, 8'h30, 8'h10);
      check({6'h00, irqReq.ovf, irqReq.edgeEv}, 8'h01);
      wr(PAC_OFF_FLAG2, 8'h10);
      rd_chk(PAC_OFF_FLAG2, 8'h30, 8'h00);
      wr(PAC_OFF_MASK2, 8'h00);
      wr(PAC_OFF_CONTROL, 8'h40);
      wr(PAC_OFF_COUNT, 8'h10);
      pac_pin_model_inst.pulses(3, 3);
      rd_chk(PAC_OFF_COUNT, 8'hFF, 8'h13);
   endtask

   // With the enable off, edges neither count nor raise the edge flag.
   task automatic t_disabled();
      wr(PAC_OFF_CONTROL, 8'h10);
      wr(PAC_OFF_FLAG2, 8'h30);
      wr(PAC_OFF_COUNT, 8'h33);
      pac_pin_model_inst.pulses(4, 2);
      rd_chk(PAC_OFF_COUNT, 8'hFF, 8'h33);
      rd_chk(PAC_OFF_FLAG2, 8'h30, 8'h00);
      // A wrap with the overflow enable on raises the request at once.
      wr(PAC_OFF_MASK2, 8'h20);
      wr(PAC_OFF_CONTROL, 8'h50);
      wr(PAC_OFF_COUNT, 8'hFF);
      pac_pin_model_inst.pulses(1, 2);
      check({7'h00, irqReq.ovf}, 8'h01);
      wr(PAC_OFF_FLAG2, 8'h30);
      wr(PAC_OFF_MASK2, 8'h00);
   endtask

   // Any 256-cycle gate window holds exactly four divide-by-64 ticks.
   task automatic t_gated();
      wr(PAC_OFF_CONTROL, 8'h60);
      wr(PAC_OFF_COUNT, 8'h00);
      pac_pin_model_inst.hold(1'b1, 256);
      pac_pin_model_inst.hold(1'b0, 2);
      rd_chk(PAC_OFF_COUNT, 8'hFF, 8'h04);
      pac_pin_model_inst.hold(1'b0, 256);
      rd_chk(PAC_OFF_COUNT, 8'hFF, 8'h04);
      // Park the pin high while disabled so the new polarity starts clean.
      wr(PAC_OFF_CONTROL, 8'h00);
      pac_pin_model_inst.hold(1'b1, 2);
      wr(PAC_OFF_CONTROL, 8'h70);
      wr(PAC_OFF_COUNT, 8'h00);
      pac_pin_model_inst.hold(1'b0, 256);
      pac_pin_model_inst.hold(1'b1, 2);
      rd_chk(PAC_OFF_COUNT, 8'hFF, 8'h04);
   endtask

   // Wait for a rising periodic request, bounded.
   task automatic wait_rise(output int t);
      logic prev;
      prev = 1'b1;
      t = -1;
      for (int i = 0; i < 400 && t < 0; i++) begin
         @(posedge ref_clk);
         #1;
         if (irqReq.periodic === 1'b1 && !prev)
            t = cyc;
         prev = (irqReq.periodic === 1'b1);
      end
      if (t < 0) begin
         nErrors++;
         test_done();
      end
   endtask

   // Every rate; a late clear must not stretch the measured period.
   task automatic t_periodic();
      int t0;
      int t1;
      wr(PAC_OFF_MASK2, 8'h40);
      for (int r = 0; r < 4; r++) begin
         wr(PAC_OFF_CONTROL, 8'(r));
         wr(PAC_OFF_FLAG2, 8'h40);
         wait_rise(t0);
         repeat (r) @(posedge ref_clk);
         wr(PAC_OFF_FLAG2, 8'h40);
         wait_rise(t1);
         check(8'(t1 - t0), 8'(1 << (PLOG2 + r)));
      end
   endtask

   // Main sequence.
   initial begin
      nErrors = 0;
      nCompared = 0;
      srst = 1'b1;
      busReq = '0;
      do_reset();
      t_regs();
      t_count();
      t_event();
      t_disabled();
      t_gated();
      t_periodic();
      test_done();
   end
endmodule // pulse_accumulator_counter_bench
